// file: rtl/io_module.sv
`timescale 1ns/1ps
module io_module
    import dio_pkg::*;
(
    input  wire logic        clk,                         // 25 MHz
    input  wire logic        rstn,                        // sync reset, low
    input  wire logic [31:0] awaddr,                      // write address
    input  wire logic [2:0]  awprot,                      // bit0 privileged
    input  wire logic        awvalid,                     // aw valid
    output logic             awready,                     // aw ready
    input  wire logic [31:0] wdata,                       // write data
    input  wire logic [3:0]  wstrb,                       // byte strobes
    input  wire logic        wvalid,                      // w valid
    output logic             wready,                      // w ready
    output logic [1:0]       bresp,                       // write resp
    output logic             bvalid,                      // b valid
    input  wire logic        bready,                      // b ready
    input  wire logic [31:0] araddr,                      // read address
    input  wire logic [2:0]  arprot,                      // bit0 privileged
    input  wire logic        arvalid,                     // ar valid
    output logic             arready,                     // ar ready
    output logic [31:0]      rdata,                       // read data
    output logic [1:0]       rresp,                       // read resp
    output logic             rvalid,                      // r valid
    input  wire logic        rready,                      // r ready
    input  wire logic [63:0] port_in,                     // port pins in
    output logic      [63:0] port_out,                    // port pins out
    output logic      [63:0] port_oe,                     // port drive
    input  wire logic [7:0]  irq_in,                      // interrupt lines
    input  wire logic [7:0]  edge_select_jumpers,         // 1 rising
    input  wire logic [2:0]  irq_level_switches,          // level 1..7
    input  wire logic        address_space_jumper,        // 1 standard
    input  wire logic [6:0]  base_and_privilege_switches, // base, sup only
    output logic [7:0]       flag_out,                    // flag lines
    output logic             irq_req,                     // level request
    output logic [2:0]       irq_level,                   // request level
    input  wire logic        iack_req,                    // ack cycle pulse
    input  wire logic [2:0]  iack_level,                  // acked level
    output logic             iack_ack,                    // vector valid
    output logic [7:0]       vector_out                   // ack vector
);
    localparam int SW = 91;

    dio_link_if lk ();

    dio_id_rom u_rom (
        .clk  (clk),
        .rstn (rstn),
        .lk   (lk)
    );

    dio_irq_latch u_irq (
        .clk  (clk),
        .rstn (rstn),
        .lk   (lk)
    );

    logic [SW-1:0]    s1;
    logic [SW-1:0]    s2;
    logic [SW-1:0]    s3;
    logic [SW-1:0]    cl;
    logic [63:0]      pin;
    logic [5:0]       base;
    logic             sup_only;
    logic             std_space;
    logic [2:0]       lvl;
    logic [NPORT-1:0] dir;
    logic [NLINE-1:0] mask;
    logic [7:0]       vec;
    logic             ie;
    logic [63:0]      dmask;
    logic [63:0]      prd;
    logic [NLINE-1:0] pend;
    logic             aw_got;
    logic             w_got;
    logic [31:0]      wa;
    logic [2:0]       wp;
    logic [15:0]      wd;
    logic [1:0]       ws;
    logic             commit;
    logic             wr_hit;
    logic [31:0]      ra;
    logic [2:0]       rp;
    rd_state_t        rd_state;
    logic [15:0]      next_rdata;

    // pins and straps: three stages, change taken when 2 and 3 agree
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            cl <= '0;
        end else begin
            s1 <= {port_in, irq_in, edge_select_jumpers, irq_level_switches,
                   address_space_jumper, base_and_privilege_switches};
            s2 <= s1;
            s3 <= s2;
            cl <= (s2 & s3) | (cl & (s2 ^ s3));
        end
    end

    assign pin          = cl[90:27];
    assign lk.lines     = cl[26:19];
    assign lk.edge_rise = cl[18:11];
    assign lvl          = cl[10:8];
    assign std_space    = cl[7];
    assign sup_only     = cl[6];
    assign base         = cl[5:0];

    // window check: space, page, base, address modifier, privilege
    function automatic logic hit_f(input logic [31:0] a, input logic [2:0] p);
        logic [5:0] am;
        logic       am_ok;
        am = std_space ? (p[0] ? AM_STD_SUP : AM_STD_NP)
                       : (p[0] ? AM_SHORT_SUP : AM_SHORT_NP);
        am_ok = (am == AM_SHORT_SUP) || (am == AM_STD_SUP)
              || (!sup_only && ((am == AM_SHORT_NP) || (am == AM_STD_NP)));
        hit_f = (a[31:24] == 8'h00)
              && (a[23:16] == (std_space ? STD_PAGE : SHORT_PAGE))
              && (a[15:10] == base)
              && am_ok;
    endfunction : hit_f

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_dir
            assign dmask[g*8 +: 8] = {8{dir[g]}};
        end
    endgenerate

    assign prd  = (port_out & dmask) | (pin & ~dmask);
    assign pend = lk.latched & mask;

    // write channel: address and data taken in either order
    assign commit = aw_got && w_got && !bvalid;
    always_comb wr_hit = hit_f(wa, wp);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            awready <= 1'b0;
            aw_got  <= 1'b0;
            wa      <= 32'h0000_0000;
            wp      <= 3'h0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got  <= 1'b1;
            wa      <= awaddr;
            wp      <= awprot;
        end else if (commit) begin
            aw_got  <= 1'b0;
        end else if (!aw_got && !bvalid) begin
            awready <= 1'b1;
        end
    end

    // only the low half carries data: a 16-bit slave
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wready <= 1'b0;
            w_got  <= 1'b0;
            wd     <= 16'h0000;
            ws     <= 2'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_got  <= 1'b1;
            wd     <= wdata[15:0];
            ws     <= wstrb[1:0];
        end else if (commit) begin
            w_got  <= 1'b0;
        end else if (!w_got && !bvalid) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (commit) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // soft reset and line clears leave as one-cycle pulses
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lk.srst <= 1'b0;
            lk.clr  <= '0;
        end else begin
            lk.srst <= commit && wr_hit && ws[0] && (wa[9:0] == OFF_CTRL) && wd[CTRL_SRST];
            lk.clr  <= (commit && wr_hit && ws[0] && (wa[9:0] == OFF_CLR)) ? wd[7:0] : '0;
        end
    end

    // direction, mask and interrupt enable returned to defaults by either reset; vector, flags and port data by rstn only
    always_ff @(posedge clk) begin
        if (!rstn || lk.srst) begin
            dir  <= DIR_RST;
            mask <= MASK_RST;
            ie   <= 1'b0;
        end else if (commit && wr_hit && ws[0]) begin
            case (wa[9:0])
                OFF_DIR:  dir  <= wd[7:0];
                OFF_MASK: mask <= wd[7:0];
                OFF_CTRL: ie   <= wd[CTRL_IE];
                default:  ie   <= ie;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            port_out <= '0;
            vec      <= VEC_RST;
            flag_out <= FLAG_RST;
        end else if (commit && wr_hit && ws[0]) begin
            if (wa[9:5] == OFF_PORT[9:5]) begin
                port_out[{wa[4:2], 3'b000} +: 8] <= wd[7:0];
            end
            if (wa[9:0] == OFF_VEC) begin
                vec <= wd[7:0];
            end
            if (wa[9:0] == OFF_FLAG) begin
                flag_out <= wd[7:0];
            end
        end
    end

    // drive follows the direction bits one cycle later
    always_ff @(posedge clk) begin
        if (!rstn) begin
            port_oe <= '0;
        end else begin
            port_oe <= dmask;
        end
    end

    // a switch value of zero leaves the interrupter silent
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_req   <= 1'b0;
            irq_level <= 3'h0;
        end else begin
            irq_req   <= ie && (|pend) && (lvl != 3'h0);
            irq_level <= lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            iack_ack   <= 1'b0;
            vector_out <= 8'h00;
        end else if (iack_req && irq_req && (iack_level == irq_level)) begin
            iack_ack   <= 1'b1;
            vector_out <= vec;
        end else begin
            iack_ack   <= 1'b0;
        end
    end

    // read channel; rom address follows araddr while idle
    assign lk.rom_addr = (rd_state == RD_IDLE) ? araddr[4:2] : ra[4:2];

    always_comb begin
        next_rdata = 16'h0000;
        if (ra[9:5] == OFF_ID[9:5]) begin
            next_rdata = lk.rom_data;
        end else if (ra[9:5] == OFF_PORT[9:5]) begin
            next_rdata = {8'h00, prd[{ra[4:2], 3'b000} +: 8]};
        end else begin
            case (ra[9:0])
                OFF_CTRL:  next_rdata = {13'h0000, irq_req, 1'b0, ie};
                OFF_DIR:   next_rdata = {8'h00, dir};
                OFF_IRQIN: next_rdata = {8'h00, lk.lines};
                OFF_MASK:  next_rdata = {8'h00, mask};
                OFF_PEND:  next_rdata = {8'h00, pend};
                OFF_VEC:   next_rdata = {8'h00, vec};
                OFF_FLAG:  next_rdata = {8'h00, flag_out};
                default:   next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_state <= RD_IDLE;
            arready  <= 1'b0;
            ra       <= 32'h0000_0000;
            rp       <= 3'h0;
            rvalid   <= 1'b0;
            rdata    <= 32'h0000_0000;
            rresp    <= RESP_OKAY;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    if (arvalid && arready) begin
                        arready  <= 1'b0;
                        ra       <= araddr;
                        rp       <= arprot;
                        rd_state <= RD_WAIT;
                    end else begin
                        arready  <= 1'b1;
                    end
                end
                RD_WAIT: begin
                    rvalid   <= 1'b1;
                    rdata    <= hit_f(ra, rp) ? {16'h0000, next_rdata} : 32'h0000_0000;
                    rresp    <= hit_f(ra, rp) ? RESP_OKAY : RESP_DECERR;
                    rd_state <= RD_RESP;
                end
                RD_RESP: begin
                    if (rready) begin
                        rvalid   <= 1'b0;
                        rd_state <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= RD_IDLE;
                end
            endcase
        end
    end
endmodule : io_module

// file: include/dio_pkg.sv
package dio_pkg;
    localparam int NPORT = 8;
    localparam int NLINE = 8;
    localparam int ID_AW = 3;

    localparam logic [9:0] OFF_ID    = 10'h000;
    localparam logic [9:0] OFF_CTRL  = 10'h080;
    localparam logic [9:0] OFF_PORT  = 10'h100;
    localparam logic [9:0] OFF_DIR   = 10'h120;
    localparam logic [9:0] OFF_IRQIN = 10'h124;
    localparam logic [9:0] OFF_CLR   = 10'h128;
    localparam logic [9:0] OFF_MASK  = 10'h12C;
    localparam logic [9:0] OFF_PEND  = 10'h130;
    localparam logic [9:0] OFF_VEC   = 10'h134;
    localparam logic [9:0] OFF_FLAG  = 10'h138;

    localparam int CTRL_IE   = 0;
    localparam int CTRL_SRST = 1;
    localparam int CTRL_IRQ  = 2;

    localparam logic [5:0] AM_SHORT_NP  = 6'h29;
    localparam logic [5:0] AM_SHORT_SUP = 6'h2D;
    localparam logic [5:0] AM_STD_NP    = 6'h39;
    localparam logic [5:0] AM_STD_SUP   = 6'h3D;
    localparam logic [7:0] SHORT_PAGE   = 8'h00;
    localparam logic [7:0] STD_PAGE     = 8'h01;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    localparam logic [7:0] DIR_RST  = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] VEC_RST  = 8'h0F;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [2:0] ARM_CNT  = 3'h5;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_WAIT = 3'b010,
        RD_RESP = 3'b100
    } rd_state_t;
endpackage : dio_pkg

// file: include/dio_link_if.sv
`timescale 1ns/1ps
interface dio_link_if;
    import dio_pkg::*;
    logic [ID_AW-1:0] rom_addr;
    logic [15:0]      rom_data;
    logic [NLINE-1:0] lines;
    logic [NLINE-1:0] edge_rise;
    logic [NLINE-1:0] clr;
    logic [NLINE-1:0] latched;
    logic             srst;

    modport core (output rom_addr, lines, edge_rise, clr, srst,
                  input  rom_data, latched);
    modport rom  (input rom_addr, output rom_data);
    modport irq  (input lines, edge_rise, clr, srst, output latched);
endinterface : dio_link_if

// file: rtl/dio_id_rom.sv
`timescale 1ns/1ps
module dio_id_rom
    import dio_pkg::*;
(
    input wire logic clk,  // system clock
    input wire logic rstn, // sync reset, low
    dio_link_if.rom  lk    // address in, data out
);
    // ascii text, two characters a word, high byte first
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lk.rom_data <= 16'h0000;
        end else begin
            case (lk.rom_addr)
                3'h0: lk.rom_data <= 16'h4449;
                3'h1: lk.rom_data <= 16'h4749;
                3'h2: lk.rom_data <= 16'h4F20;
                3'h3: lk.rom_data <= 16'h3634;
                3'h4: lk.rom_data <= 16'h2038;
                3'h5: lk.rom_data <= 16'h494E;
                3'h6: lk.rom_data <= 16'h5420;
                3'h7: lk.rom_data <= 16'h3031;
                default: lk.rom_data <= 16'h0000;
            endcase
        end
    end
endmodule : dio_id_rom

// file: rtl/dio_irq_latch.sv
`timescale 1ns/1ps
module dio_irq_latch
    import dio_pkg::*;
(
    input wire logic clk,  // system clock
    input wire logic rstn, // sync reset, low
    dio_link_if.irq  lk    // lines in, latches out
);
    logic [NLINE-1:0] prev;
    logic [NLINE-1:0] hit;
    logic [2:0]       arm;

    genvar g;
    generate
        for (g = 0; g < NLINE; g++) begin : g_edge
            assign hit[g] = lk.edge_rise[g] ? (lk.lines[g] & ~prev[g])
                                            : (~lk.lines[g] & prev[g]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev <= '0;
        end else begin
            prev <= lk.lines;
        end
    end

    // filtered lines start at zero; ignore edges until they settle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            arm <= 3'h0;
        end else if (arm != ARM_CNT) begin
            arm <= arm + 3'h1;
        end
    end

    // a new edge wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn || lk.srst) begin
            lk.latched <= '0;
        end else begin
            lk.latched <= (lk.latched & ~lk.clr) | (hit & {NLINE{arm == ARM_CNT}});
        end
    end
endmodule : dio_irq_latch

// file: dv/dio_peer.sv
`timescale 1ns/1ps
module dio_peer
    import dio_pkg::*;
(
    input  wire logic [63:0] port_out, // device data
    input  wire logic [63:0] port_oe,  // device drive
    input  wire logic [63:0] pat,      // peripheral data
    output logic      [63:0] port_in   // pin level
);
    // driven bytes echo the device
    always_comb begin
        for (int n = 0; n < NPORT; n++) begin
            port_in[8*n+:8] = port_oe[8*n] ? port_out[8*n+:8] : pat[8*n+:8];
        end
    end
endmodule : dio_peer

// file: dv/io_module_chk.sv
`timescale 1ns/1ps
module io_module_chk
    import dio_pkg::*;
(
    input wire logic        clk,                // clock
    input wire logic        rstn,               // reset, low
    input wire logic        arvalid,            // ar valid
    input wire logic        arready,            // ar ready
    input wire logic [31:0] rdata,              // read data
    input wire logic [1:0]  rresp,              // read resp
    input wire logic        rvalid,             // r valid
    input wire logic        rready,             // r ready
    input wire logic        bvalid,             // b valid
    input wire logic        bready,             // b ready
    input wire logic [63:0] port_oe,            // port drive
    input wire logic [7:0]  flag_out,           // flags
    input wire logic        irq_req,            // request
    input wire logic [2:0]  irq_level,          // request level
    input wire logic [2:0]  irq_level_switches, // level straps
    input wire logic        iack_req,           // ack cycle
    input wire logic [2:0]  iack_level,         // acked level
    input wire logic        iack_ack,           // vector valid
    input wire logic [7:0]  vector_out          // vector
);
    logic accept;
    logic oe_ok;
    assign accept = iack_req && irq_req && (iack_level == irq_level);
    // ports turn as whole bytes
    always_comb begin
        oe_ok = 1'b1;
        for (int n = 0; n < NPORT; n++) begin
            if (port_oe[8*n+:8] != {8{port_oe[8*n]}}) oe_ok = 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_rst_outputs: assert property ($rose(rstn) |-> flag_out == 8'h00 && port_oe == 64'h0 && !irq_req)
        else $error("outputs not at reset value");
    chk_oe_bytes: assert property (oe_ok)
        else $error("port drive split inside a byte");
    chk_level_copy: assert property ($stable(irq_level_switches) [*8] |-> ##3 irq_level == irq_level_switches)
        else $error("request level does not follow switches");
    chk_req_level: assert property (irq_req |-> irq_level != 3'h0)
        else $error("request on level zero");
    chk_iack_answer: assert property (accept |=> iack_ack)
        else $error("acknowledge not answered");
    chk_iack_cause: assert property (iack_ack |-> $past(accept))
        else $error("vector without matching acknowledge");
    chk_vec_hold: assert property (!iack_ack |-> $stable(vector_out))
        else $error("vector changed outside acknowledge");
    chk_b_release: assert property (bvalid && bready |=> !bvalid)
        else $error("write response not released");
    chk_r_release: assert property (rvalid && rready |=> !rvalid)
        else $error("read response not released");
    chk_ar_answer: assert property (arvalid && arready |-> ##2 rvalid)
        else $error("read answer late");
    chk_decerr_zero: assert property (rvalid && rresp == RESP_DECERR |-> rdata == 32'h0)
        else $error("refused read returned data");
    chk_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0)
        else $error("read data wider than 16 bits");
    cov_iack: cover property (accept ##1 iack_ack);
    cov_decerr: cover property (rvalid && rresp == RESP_DECERR);
    cov_irq: cover property ($rose(irq_req));
endmodule : io_module_chk
bind io_module io_module_chk u_chk (.clk(clk), .rstn(rstn), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bvalid(bvalid), .bready(bready),
    .port_oe(port_oe), .flag_out(flag_out), .irq_req(irq_req), .irq_level(irq_level),
    .irq_level_switches(irq_level_switches), .iack_req(iack_req), .iack_level(iack_level),
    .iack_ack(iack_ack), .vector_out(vector_out));

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dio_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [31:0] awaddr, wdata, araddr, rdata, rdat;
    logic [2:0]  awprot, arprot, irq_level_switches, irq_level, iack_level;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [63:0] port_in, port_out, port_oe, pat;
    logic [7:0]  irq_in, edge_select_jumpers, flag_out, vector_out;
    logic        address_space_jumper, irq_req, iack_req, iack_ack;
    logic [6:0]  base_and_privilege_switches;
    logic [5:0]  base = 6'h05;
    int          err_total, n_compared;

    io_module uut (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .irq_in(irq_in),
        .edge_select_jumpers(edge_select_jumpers), .irq_level_switches(irq_level_switches),
        .address_space_jumper(address_space_jumper), .base_and_privilege_switches(base_and_privilege_switches),
        .flag_out(flag_out), .irq_req(irq_req), .irq_level(irq_level), .iack_req(iack_req),
        .iack_level(iack_level), .iack_ack(iack_ack), .vector_out(vector_out));
    dio_peer peer (.port_out(port_out), .port_oe(port_oe), .pat(pat), .port_in(port_in));

    always #20 clk = ~clk;

    task automatic wrap_up;
        if (err_total == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] ad(input logic [9:0] off, input logic [7:0] pg = SHORT_PAGE);
        return {8'h00, pg, base, off};
    endfunction : ad

    task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic pr = 1'b1);
        int k;
        @(posedge clk);
        awaddr <= a;
        awprot <= {2'b00, pr};
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        rsp = bresp;
        bready <= 1'b0;
        if (k == 64) begin
            err_total++;
            wrap_up();
        end
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic pr = 1'b1);
        int k;
        @(posedge clk);
        araddr <= a;
        arprot <= {2'b00, pr};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rdat = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (k == 64) begin
            err_total++;
            wrap_up();
        end
    endtask : rd

    task automatic t_reset;
        logic [9:0] offs[5] = '{OFF_DIR, OFF_MASK, OFF_VEC, OFF_FLAG, OFF_CTRL};
        logic [7:0] vals[5] = '{DIR_RST, MASK_RST, VEC_RST, FLAG_RST, 8'h00};
        for (int i = 0; i < 5; i++) begin
            rd(ad(offs[i]));
            check("reset value", rdat, {56'h0, vals[i]});
        end
        rd(ad(OFF_ID));
        check("id word", rdat, 64'h4449);
        wr(ad(OFF_ID), 16'h1234);
        rd(ad(OFF_ID));
        check("id read only", rdat, 64'h4449);
    endtask : t_reset

    task automatic t_ports;
        pat <= 64'h8877665544332211;
        wr(ad(OFF_PORT), 16'h00A5);
        wr(ad(OFF_PORT + 10'h008), 16'h003C);
        wr(ad(OFF_DIR), 16'h0005);
        repeat (8) @(posedge clk);
        check("port drive", port_oe, 64'h0000_0000_00FF_00FF);
        check("port 0 out", port_out[7:0], 64'hA5);
        rd(ad(OFF_PORT + 10'h004));
        check("port 1 in", rdat, 64'h22);
        rd(ad(OFF_PORT + 10'h008));
        check("port 2 out", rdat, 64'h3C);
        rd(ad(OFF_PORT + 10'h01C));
        check("port 7 in", rdat, 64'h88);
    endtask : t_ports

    task automatic t_irq;
        wr(ad(OFF_MASK), 16'h00FF);
        wr(ad(OFF_CTRL), 16'h0001);
        irq_in <= 8'hE1;
        repeat (8) @(posedge clk);
        rd(ad(OFF_PEND));
        check("pending both edges", rdat, 64'h11);
        check("request", irq_req, 64'h1);
        wr(ad(OFF_MASK), 16'h0010);
        rd(ad(OFF_PEND));
        check("pending masked", rdat, 64'h10);
        wr(ad(OFF_CLR), 16'h0010);
        rd(ad(OFF_PEND));
        check("pending cleared", rdat, 64'h00);
        check("request masked", irq_req, 64'h0);
        wr(ad(OFF_MASK), 16'h00FF);
        rd(ad(OFF_PEND));
        check("other line kept", rdat, 64'h01);
        wr(ad(OFF_CTRL), 16'h0000);
        repeat (2) @(posedge clk);
        check("request disabled", irq_req, 64'h0);
        wr(ad(OFF_CLR), 16'h0001);
        irq_in <= 8'hF0;
        repeat (8) @(posedge clk);
        rd(ad(OFF_PEND));
        check("wrong edge ignored", rdat, 64'h00);
    endtask : t_irq

    task automatic t_iack;
        wr(ad(OFF_VEC), 16'h0042);
        wr(ad(OFF_CTRL), 16'h0001);
        irq_in <= 8'hE1;
        repeat (8) @(posedge clk);
        check("level", irq_level, 64'h3);
        for (int lv = 2; lv < 4; lv++) begin
            @(posedge clk);
            iack_req <= 1'b1;
            iack_level <= 3'(lv);
            @(posedge clk);
            iack_req <= 1'b0;
            @(negedge clk);
            check("ack", iack_ack, 64'(lv == 3));
        end
        check("vector", vector_out, 64'h42);
    endtask : t_iack

    task automatic t_flags_srst;
        wr(ad(OFF_FLAG), 16'h003C);
        @(negedge clk);
        check("flags", flag_out, 64'h3C);
        wr(ad(OFF_CTRL), 16'h0002);
        repeat (3) @(posedge clk);
        check("drive after soft reset", port_oe, 64'h0);
        check("request after soft reset", irq_req, 64'h0);
        for (int i = 0; i < 4; i++) begin
            rd(ad(OFF_DIR + 10'(4 * i)));
            check("cleared by soft reset", rdat, (i == 1) ? 64'hE1 : 64'h0);
        end
        wr(ad(OFF_MASK), 16'h00FF);
        rd(ad(OFF_PEND));
        check("latches cleared", rdat, 64'h0);
        check("flags kept", flag_out, 64'h3C);
    endtask : t_flags_srst

    task automatic t_decode;
        wr(ad(OFF_FLAG) ^ 32'h0000_0400, 16'h0000);
        check("other base", rsp, 64'(RESP_DECERR));
        check("no effect", flag_out, 64'h3C);
        rd(ad(OFF_VEC, STD_PAGE));
        check("standard refused", rsp, 64'(RESP_DECERR));
        address_space_jumper <= 1'b1;
        repeat (8) @(posedge clk);
        rd(ad(OFF_VEC, STD_PAGE));
        check("standard read", rdat, 64'h42);
        rd(ad(OFF_VEC));
        check("short refused", rsp, 64'(RESP_DECERR));
        address_space_jumper <= 1'b0;
        base_and_privilege_switches <= {1'b1, base};
        repeat (8) @(posedge clk);
        rd(ad(OFF_VEC), 1'b0);
        check("user refused", rsp, 64'(RESP_DECERR));
        rd(ad(OFF_VEC));
        check("supervisor read", rdat, 64'h42);
        rd(ad(10'h3FC));
        check("unused offset", {rsp, rdat}, {2'(RESP_OKAY), 32'h0});
    endtask : t_decode

    initial begin
        {awaddr, wdata, araddr, awprot, arprot, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready, iack_req, address_space_jumper} = '0;
        pat = 64'h0;
        iack_level = 3'h0;
        irq_in = 8'hF0;
        edge_select_jumpers = 8'h0F;
        irq_level_switches = 3'h3;
        base_and_privilege_switches = {1'b0, base};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_ports();
        t_irq();
        t_iack();
        t_flags_srst();
        t_decode();
        wrap_up();
    end
endmodule : testbench
